// [sic_chopper.sv]
// Fixed off-time chopper for one H-bridge with blanking and slow, fast or mixed decay.
`timescale 1ns/100ps
`default_nettype none
`include "sic_params.svh"
module sic_chopper (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control from the indexer
	input wire logic run,
	input wire logic pol,
	input wire logic decreasing,
	input wire logic [1:0] decay,
	input wire logic sync_rectify_n,
	input wire logic [15:0] t_off,
	input wire logic [15:0] t_blank,
	input wire logic [15:0] t_fd,
	// Analogue status, already synchronised
	input wire logic cmp,
	input wire logic zero,
	// Gates: {pos high, pos low, neg high, neg low}
	output logic [3:0] gate
);

	sic_pkg::sic_chop_t s_q;
	sic_pkg::sic_chop_t s_d;
	logic [15:0] cnt_inc;
	logic fast_ok;

	always_comb begin
		s_d = s_q;
		cnt_inc = s_q.cnt + 16'h0001;
		fast_ok = decreasing && (decay == `SIC_DECAY_FAST || decay == `SIC_DECAY_MIXED);
		case (s_q.st)
			sic_pkg::SIC_IDLE: begin
				s_d.cnt = 16'h0000;
				if (run) begin
					s_d.st = sic_pkg::SIC_DRIVE;
				end
			end
			sic_pkg::SIC_DRIVE: begin
				if (s_q.cnt < t_blank) begin
					s_d.cnt = cnt_inc;
				end else if (cmp) begin
					// The comparator already weighs eight times the sense voltage against the scaled reference.
					s_d.cnt = 16'h0000;
					s_d.zero_seen = 1'b0;
					s_d.st = fast_ok ? sic_pkg::SIC_FAST : sic_pkg::SIC_SLOW;
				end
			end
			sic_pkg::SIC_FAST: begin
				s_d.cnt = cnt_inc;
				if (zero) begin
					s_d.zero_seen = 1'b1;
				end
				if (decay == `SIC_DECAY_MIXED && cnt_inc >= t_fd) begin
					s_d.st = sic_pkg::SIC_SLOW;
				end
				if (cnt_inc >= t_off) begin
					s_d.st = sic_pkg::SIC_DRIVE;
					s_d.cnt = 16'h0000;
				end
			end
			sic_pkg::SIC_SLOW: begin
				s_d.cnt = cnt_inc;
				if (cnt_inc >= t_off) begin
					s_d.st = sic_pkg::SIC_DRIVE;
					s_d.cnt = 16'h0000;
				end
			end
			default: begin
				s_d.st = sic_pkg::SIC_IDLE;
			end
		endcase
		if (!run) begin
			s_d.st = sic_pkg::SIC_IDLE;
			s_d.cnt = 16'h0000;
		end
		case (s_d.st)
			sic_pkg::SIC_DRIVE: begin
				s_d.gate = pol ? 4'b1001 : 4'b0110;
			end
			sic_pkg::SIC_FAST: begin
				// Reverse drive is dropped at zero current so the winding never charges the other way.
				if (!sync_rectify_n && !s_d.zero_seen) begin
					s_d.gate = pol ? 4'b0110 : 4'b1001;
				end else begin
					s_d.gate = 4'b0000;
				end
			end
			sic_pkg::SIC_SLOW: begin
				s_d.gate = 4'b0101;
			end
			default: begin
				s_d.gate = 4'b0000;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{st: sic_pkg::SIC_IDLE, cnt: 16'h0000, zero_seen: 1'b0, gate: 4'b0000};
		end else begin
			s_q <= s_d;
		end
	end

	assign gate = s_q.gate;

endmodule
`default_nettype wire

// [sic_motion_ctl.sv]
// Motion controller model that issues step pulses with direction set up ahead of each rise.
`timescale 1ns/100ps
`default_nettype none
module sic_motion_ctl (
	// Clock
	input wire logic clk,
	// Step interface pins
	output var logic step,
	output var logic dir
);
	initial begin
		step = 1'b0;
		dir = 1'b1;
	end
	// Four cycles each for setup, high and low, beyond the two the synchroniser needs.
	task automatic pulse(input logic d);
		dir <= d;
		repeat (4) @(posedge clk);
		step <= 1'b1;
		repeat (4) @(posedge clk);
		step <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// [sic_params.svh]
// Constants of the stepper indexer and chopper: timing, register map, codes and pin positions.
`ifndef SIC_PARAMS_SVH
`define SIC_PARAMS_SVH

`define SIC_CLK_NS 10
`define SIC_TOFF_DEF_NS 38000
`define SIC_BLANK_DEF_NS 950
`define SIC_FD_DEF_NS 10000
`define SIC_TOFF_DEF_CYC (`SIC_TOFF_DEF_NS / `SIC_CLK_NS)
`define SIC_BLANK_DEF_CYC ((`SIC_BLANK_DEF_NS + `SIC_CLK_NS - 1) / `SIC_CLK_NS)
`define SIC_FD_DEF_CYC (`SIC_FD_DEF_NS / `SIC_CLK_NS)

`define SIC_REG_CTRL 6'h00
`define SIC_REG_TIME0 6'h01
`define SIC_REG_TIME5 6'h06
`define SIC_REG_STATUS 6'h07
`define SIC_ST_POS 0
`define SIC_ST_HOME 5
`define SIC_ST_FAULT 6
`define SIC_ST_RUN 7
`define SIC_ST_MAG_A 8
`define SIC_ST_POL_A 15
`define SIC_ST_MAG_B 16
`define SIC_ST_POL_B 23
`define SIC_ST_DEC_A 24
`define SIC_ST_DEC_B 25
`define SIC_TOFF_IDX 0
`define SIC_BLANK_IDX 2
`define SIC_FD_IDX 4
`define SIC_NTIME 6

`define SIC_DECAY_SLOW 2'h0
`define SIC_DECAY_FAST 2'h1
`define SIC_DECAY_MIXED 2'h2

`define SIC_HOME_POS 5'h04
`define SIC_HOME_MAG 7'h47
`define SIC_QUARTER 5'h08
`define SIC_HALF_TURN 5'h10
`define SIC_INC_FULL 5'h08
`define SIC_INC_HALF 5'h04
`define SIC_INC_QUARTER 5'h02
`define SIC_INC_EIGHTH 5'h01

`define SIC_HSIZE_WORD 3'h2
`define SIC_HRESP_OKAY 1'b0

`define SIC_IN_STEP 0
`define SIC_IN_DIR 1
`define SIC_IN_MS_LO 2
`define SIC_IN_MS_HI 3
`define SIC_IN_CLEAR_N 4
`define SIC_IN_DRIVE_ON_N 5
`define SIC_IN_LOW_POWER_N 6
`define SIC_IN_SR_N 7
`define SIC_IN_OCP 8
`define SIC_IN_CMP 9
`define SIC_IN_ZERO 11
`define SIC_NIN 13

`endif

// [sic_pkg.sv]
// Types shared by the stepper indexer and chopper modules.
package sic_pkg;

	typedef enum logic [2:0] {
		SIC_IDLE,
		SIC_DRIVE,
		SIC_FAST,
		SIC_SLOW
	} sic_chop_st_t;

	typedef struct packed {
		sic_chop_st_t st;
		logic [15:0] cnt;
		logic zero_seen;
		logic [3:0] gate;
	} sic_chop_t;

	typedef struct packed {
		logic step_prev;
		logic [4:0] pos;
		logic fault;
		logic fault_armed;
		logic run;
		logic home_n;
		logic [6:0] mag_a;
		logic [6:0] mag_b;
		logic pol_a;
		logic pol_b;
		logic dec_a;
		logic dec_b;
		logic [1:0] decay;
		logic [5:0][15:0] tcfg;
		logic ph_wr;
		logic [5:0] ph_idx;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} sic_top_t;

endpackage

// [sic_sync.sv]
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/100ps
`default_nettype none
module sic_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins in, synchronised levels out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sic_sync_t;

	sic_sync_t s_q;
	sic_sync_t s_d;

	always_comb begin
		s_d.s1 = d;
		s_d.s2 = s_q.s1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q = s_q.s2;

endmodule
`default_nettype wire

// [sic_top.sv]
// Stepper indexer with two bridge choppers and an AHB-Lite register slave.
//
// Summary of operation
// - Drive ends when eight times the sense voltage reaches the winding's reference.
// - Each winding's reference is scaled by a table value from the indexer position.
// - After the threshold the winding is undriven for a fixed off-time, then resumes.
// - Off-time is set separately for bridge A and bridge B.
// - The comparator is ignored for a blanking time right after the bridge turns on.
// - Fast decay with rectification turns on the opposite pair, off near zero current.
// - Fast decay without rectification leaves all FETs off, current flows through diodes.
// - Slow decay turns on both low-side FETs for the off-time.
// - Mixed decay starts fast and switches to slow after a set interval.
// - Fast or mixed decay only while the target falls or holds; slow decay while it rises.
// - The decay code selects slow, fast or mixed decay.
// - The fast part of mixed decay lasts a programmed time.
// - Select code 00 full, 01 half, 10 quarter, 11 eighth step.
// - Each rising step edge advances the indexer by one step of the selected mode: 8, 4, 2 or 1 positions.
// - Direction high moves forward, low backward; set before the step edge.
// - Positive current drives the positive terminal above the negative one.
// - The indexer starts at the 45 degree home position after reset.
// - The home indicator is low at home and high elsewhere.
// - Eighth-step targets follow the sine table, B mirrored, signs rotate per quarter.
// - Coarser modes visit every 2nd, 4th or 8th entry; full step uses diagonals.
// - Clear input low holds home, disables both bridges and ignores steps.
// - Drive-enable input high switches bridges off while the indexer keeps running.
// - Low-power input low disables bridges and ignores all inputs.
// - Overcurrent disables bridges, homes the indexer, until enable goes high then low.
`timescale 1ns/100ps
`default_nettype none
`include "sic_params.svh"
module sic_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Step interface pins
	input wire logic step,
	input wire logic dir,
	input wire logic microstep_sel_hi,
	input wire logic microstep_sel_lo,
	// Mode pins
	input wire logic indexer_clear_n,
	input wire logic bridge_drive_on_n,
	input wire logic low_power_n,
	input wire logic sync_rectify_n,
	// Analogue status pins
	input wire logic overcurrent,
	input wire logic cmp_a,
	input wire logic cmp_b,
	input wire logic zero_a,
	input wire logic zero_b,
	// Reference scale for the current DACs, percent of full scale
	output logic [6:0] ref_scale_a,
	output logic [6:0] ref_scale_b,
	// Bridge A gates
	output logic winding_term_pos_hs_a,
	output logic winding_term_pos_ls_a,
	output logic winding_term_neg_hs_a,
	output logic winding_term_neg_ls_a,
	// Bridge B gates
	output logic winding_term_pos_hs_b,
	output logic winding_term_pos_ls_b,
	output logic winding_term_neg_hs_b,
	output logic winding_term_neg_ls_b,
	// Home indicator
	output logic at_origin_n
);

	sic_pkg::sic_top_t s_q;
	sic_pkg::sic_top_t s_d;
	logic [`SIC_NIN-1:0] pin_raw;
	logic [`SIC_NIN-1:0] pin;
	logic [1:0][3:0] gate;
	logic [1:0] bridge_pol;
	logic [1:0] bridge_dec;

	// Cosine magnitude of an eighth-step position, in percent.
	function automatic logic [6:0] sic_cos_mag(input logic [4:0] p);
		logic [3:0] m;
		logic [3:0] d;
		logic [6:0] v;
		m = p[3:0];
		d = (m <= 4'h8) ? m : 4'(5'h10 - {1'b0, m});
		case (d)
			4'h0: v = 7'h64;
			4'h1: v = 7'h62;
			4'h2: v = 7'h5c;
			4'h3: v = 7'h53;
			4'h4: v = 7'h47;
			4'h5: v = 7'h38;
			4'h6: v = 7'h26;
			4'h7: v = 7'h14;
			default: v = 7'h00;
		endcase
		return v;
	endfunction

	// Cosine sign: negative strictly between 90 and 270 degrees.
	function automatic logic sic_cos_pos(input logic [4:0] p);
		logic [4:0] r;
		r = p + `SIC_QUARTER;
		return !(r > `SIC_HALF_TURN);
	endfunction

	assign pin_raw[`SIC_IN_STEP] = step;
	assign pin_raw[`SIC_IN_DIR] = dir;
	assign pin_raw[`SIC_IN_MS_LO] = microstep_sel_lo;
	assign pin_raw[`SIC_IN_MS_HI] = microstep_sel_hi;
	assign pin_raw[`SIC_IN_CLEAR_N] = indexer_clear_n;
	assign pin_raw[`SIC_IN_DRIVE_ON_N] = bridge_drive_on_n;
	assign pin_raw[`SIC_IN_LOW_POWER_N] = low_power_n;
	assign pin_raw[`SIC_IN_SR_N] = sync_rectify_n;
	assign pin_raw[`SIC_IN_OCP] = overcurrent;
	assign pin_raw[`SIC_IN_CMP] = cmp_a;
	assign pin_raw[`SIC_IN_CMP + 1] = cmp_b;
	assign pin_raw[`SIC_IN_ZERO] = zero_a;
	assign pin_raw[`SIC_IN_ZERO + 1] = zero_b;

	// Every pin, the analogue status included, comes from outside the clock domain.
	sic_sync #(
		.W(`SIC_NIN)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d(pin_raw),
		.q(pin)
	);

	logic step_rise;
	logic awake;
	logic clear_act;
	logic ocp_hit;
	logic [4:0] inc;
	logic [4:0] pos_nx;
	logic [6:0] mag_a_nx;
	logic [6:0] mag_b_nx;
	logic addr_ok;
	logic wr_ok;
	logic [5:0] widx;
	logic [5:0] ridx;
	logic [31:0] rd;

	always_comb begin
		s_d = s_q;
		awake = pin[`SIC_IN_LOW_POWER_N];
		clear_act = !pin[`SIC_IN_CLEAR_N];
		step_rise = pin[`SIC_IN_STEP] && !s_q.step_prev;
		ocp_hit = awake && pin[`SIC_IN_OCP];
		// The edge detector tracks the pin even while asleep, so waking never fakes a step.
		s_d.step_prev = pin[`SIC_IN_STEP];
		case ({pin[`SIC_IN_MS_HI], pin[`SIC_IN_MS_LO]})
			2'b00: inc = `SIC_INC_FULL;
			2'b01: inc = `SIC_INC_HALF;
			2'b10: inc = `SIC_INC_QUARTER;
			default: inc = `SIC_INC_EIGHTH;
		endcase
		// Steps that arrive during clear or sleep are lost, not queued.
		pos_nx = s_q.pos;
		if (awake && !clear_act && step_rise) begin
			pos_nx = pin[`SIC_IN_DIR] ? s_q.pos + inc : s_q.pos - inc;
		end
		// Overcurrent latch; the set wins over the enable-toggle release.
		if (awake && s_q.fault) begin
			if (pin[`SIC_IN_DRIVE_ON_N]) begin
				s_d.fault_armed = 1'b1;
			end else if (s_q.fault_armed) begin
				s_d.fault = 1'b0;
				s_d.fault_armed = 1'b0;
			end
		end
		if (ocp_hit) begin
			s_d.fault = 1'b1;
			s_d.fault_armed = 1'b0;
		end
		if (awake && (clear_act || ocp_hit)) begin
			pos_nx = `SIC_HOME_POS;
		end
		s_d.pos = pos_nx;
		s_d.home_n = (pos_nx != `SIC_HOME_POS);
		mag_a_nx = sic_cos_mag(pos_nx);
		mag_b_nx = sic_cos_mag(5'(pos_nx - `SIC_QUARTER));
		s_d.mag_a = mag_a_nx;
		s_d.mag_b = mag_b_nx;
		s_d.pol_a = sic_cos_pos(pos_nx);
		s_d.pol_b = sic_cos_pos(5'(pos_nx - `SIC_QUARTER));
		// Equal magnitudes count as falling, so full step, whose magnitude never changes, may use fast decay.
		if (pos_nx != s_q.pos) begin
			s_d.dec_a = !(mag_a_nx > s_q.mag_a);
			s_d.dec_b = !(mag_b_nx > s_q.mag_b);
		end
		// While asleep the indexer and latches hold their state; only the step edge detector keeps sampling.
		if (!awake) begin
			s_d.pos = s_q.pos;
			s_d.home_n = s_q.home_n;
			s_d.mag_a = s_q.mag_a;
			s_d.mag_b = s_q.mag_b;
			s_d.pol_a = s_q.pol_a;
			s_d.pol_b = s_q.pol_b;
			s_d.dec_a = s_q.dec_a;
			s_d.dec_b = s_q.dec_b;
		end
		// Gates follow one cycle after run, since each chopper registers its own gate word.
		s_d.run = awake && !clear_act && !pin[`SIC_IN_DRIVE_ON_N] && !s_d.fault;

		// Data phase of a write accepted in the previous cycle.
		widx = s_q.ph_idx;
		if (s_q.ph_wr) begin
			if (widx == `SIC_REG_CTRL) begin
				s_d.decay = hwdata[1:0];
			end else if (widx >= `SIC_REG_TIME0 && widx <= `SIC_REG_TIME5) begin
				s_d.tcfg[3'(widx - `SIC_REG_TIME0)] = hwdata[15:0];
			end
		end
		// Address phase; read data is formed from the updated copy so a read right after a write sees it.
		addr_ok = hsel && htrans[1] && hready;
		wr_ok = addr_ok && hwrite && (hsize == `SIC_HSIZE_WORD);
		ridx = haddr[7:2];
		s_d.ph_wr = wr_ok;
		s_d.ph_idx = ridx;
		rd = 32'h0000_0000;
		if (ridx == `SIC_REG_CTRL) begin
			rd[1:0] = s_d.decay;
		end else if (ridx >= `SIC_REG_TIME0 && ridx <= `SIC_REG_TIME5) begin
			rd[15:0] = s_d.tcfg[3'(ridx - `SIC_REG_TIME0)];
		end else if (ridx == `SIC_REG_STATUS) begin
			rd[`SIC_ST_POS +: 5] = s_q.pos;
			rd[`SIC_ST_HOME] = s_q.home_n;
			rd[`SIC_ST_FAULT] = s_q.fault;
			rd[`SIC_ST_RUN] = s_q.run;
			rd[`SIC_ST_MAG_A +: 7] = s_q.mag_a;
			rd[`SIC_ST_POL_A] = s_q.pol_a;
			rd[`SIC_ST_MAG_B +: 7] = s_q.mag_b;
			rd[`SIC_ST_POL_B] = s_q.pol_b;
			rd[`SIC_ST_DEC_A] = s_q.dec_a;
			rd[`SIC_ST_DEC_B] = s_q.dec_b;
		end
		// Only the low 256 bytes decode; anything above reads zero and ignores writes.
		if (haddr[31:8] != 24'h00_0000) begin
			rd = 32'h0000_0000;
			s_d.ph_wr = 1'b0;
		end
		// A misaligned access would straddle two registers, so it is refused like an unmapped one.
		if (haddr[1:0] != 2'b00) begin
			rd = 32'h0000_0000;
			s_d.ph_wr = 1'b0;
		end
		// Read data is held until the next read, so it still stands when the data phase ends.
		if (addr_ok && !hwrite) begin
			s_d.hrdata = rd;
		end
		// The slave never stretches a transfer, so every response is ready and OKAY.
		s_d.hreadyout = 1'b1;
		s_d.hresp = `SIC_HRESP_OKAY;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q.step_prev <= 1'b0;
			s_q.pos <= `SIC_HOME_POS;
			s_q.fault <= 1'b0;
			s_q.fault_armed <= 1'b0;
			s_q.run <= 1'b0;
			s_q.home_n <= 1'b0;
			// Home is 45 degrees, where both windings take the same magnitude.
			s_q.mag_a <= `SIC_HOME_MAG;
			s_q.mag_b <= `SIC_HOME_MAG;
			s_q.pol_a <= 1'b1;
			s_q.pol_b <= 1'b1;
			s_q.dec_a <= 1'b0;
			s_q.dec_b <= 1'b0;
			s_q.decay <= `SIC_DECAY_SLOW;
			for (int i = 0; i < `SIC_NTIME; i++) begin
				s_q.tcfg[i] <= 16'h0000;
			end
			s_q.tcfg[`SIC_TOFF_IDX] <= 16'(`SIC_TOFF_DEF_CYC);
			s_q.tcfg[`SIC_TOFF_IDX + 1] <= 16'(`SIC_TOFF_DEF_CYC);
			s_q.tcfg[`SIC_BLANK_IDX] <= 16'(`SIC_BLANK_DEF_CYC);
			s_q.tcfg[`SIC_BLANK_IDX + 1] <= 16'(`SIC_BLANK_DEF_CYC);
			s_q.tcfg[`SIC_FD_IDX] <= 16'(`SIC_FD_DEF_CYC);
			s_q.tcfg[`SIC_FD_IDX + 1] <= 16'(`SIC_FD_DEF_CYC);
			s_q.ph_wr <= 1'b0;
			s_q.ph_idx <= 6'h00;
			s_q.hrdata <= 32'h0000_0000;
			s_q.hreadyout <= 1'b1;
			s_q.hresp <= `SIC_HRESP_OKAY;
		end else begin
			s_q <= s_d;
		end
	end

	assign bridge_pol = {s_q.pol_b, s_q.pol_a};
	assign bridge_dec = {s_q.dec_b, s_q.dec_a};

	// One chopper per bridge; each has its own off, blanking and fast-decay times.
	for (genvar b = 0; b < 2; b++) begin : g_bridge
		sic_chopper u_chop (
			.clk(clk),
			.rst_n(rst_n),
			.run(s_q.run),
			.pol(bridge_pol[b]),
			.decreasing(bridge_dec[b]),
			.decay(s_q.decay),
			.sync_rectify_n(pin[`SIC_IN_SR_N]),
			.t_off(s_q.tcfg[`SIC_TOFF_IDX + b]),
			.t_blank(s_q.tcfg[`SIC_BLANK_IDX + b]),
			.t_fd(s_q.tcfg[`SIC_FD_IDX + b]),
			.cmp(pin[`SIC_IN_CMP + b]),
			.zero(pin[`SIC_IN_ZERO + b]),
			.gate(gate[b])
		);
	end

	assign hrdata = s_q.hrdata;
	assign hreadyout = s_q.hreadyout;
	assign hresp = s_q.hresp;
	assign ref_scale_a = s_q.mag_a;
	assign ref_scale_b = s_q.mag_b;
	// Each gate word is ordered positive high, positive low, negative high, negative low.
	assign winding_term_pos_hs_a = gate[0][3];
	assign winding_term_pos_ls_a = gate[0][2];
	assign winding_term_neg_hs_a = gate[0][1];
	assign winding_term_neg_ls_a = gate[0][0];
	assign winding_term_pos_hs_b = gate[1][3];
	assign winding_term_pos_ls_b = gate[1][2];
	assign winding_term_neg_hs_b = gate[1][1];
	assign winding_term_neg_ls_b = gate[1][0];
	assign at_origin_n = s_q.home_n;

endmodule
`default_nettype wire

// [sic_top_properties.sv]
// Port-level assertions for the stepper indexer and chopper, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
module sic_top_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins in
	input wire logic step,
	input wire logic indexer_clear_n,
	input wire logic bridge_drive_on_n,
	input wire logic low_power_n,
	input wire logic overcurrent,
	// Targets and home flag
	input wire logic [6:0] ref_scale_a,
	input wire logic [6:0] ref_scale_b,
	input wire logic at_origin_n,
	// Gates
	input wire logic winding_term_pos_hs_a,
	input wire logic winding_term_pos_ls_a,
	input wire logic winding_term_neg_hs_a,
	input wire logic winding_term_neg_ls_a,
	input wire logic winding_term_pos_hs_b,
	input wire logic winding_term_pos_ls_b,
	input wire logic winding_term_neg_hs_b,
	input wire logic winding_term_neg_ls_b
);
	logic [3:0] ga;
	logic [3:0] gb;
	assign ga = {winding_term_pos_hs_a, winding_term_pos_ls_a, winding_term_neg_hs_a, winding_term_neg_ls_a};
	assign gb = {winding_term_pos_hs_b, winding_term_pos_ls_b, winding_term_neg_hs_b, winding_term_neg_ls_b};
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Pins pass a two-flop synchroniser, so each antecedent lasts long enough to cover it.
	chk_clear_home: assert property (!indexer_clear_n [*5] |-> !at_origin_n && ref_scale_a == 7'h47)
		else $error("clear did not home the indexer");
	chk_clear_gates: assert property (!indexer_clear_n [*6] |-> ga == 4'h0 && gb == 4'h0)
		else $error("bridges driven during clear");
	chk_enable_gates: assert property (bridge_drive_on_n [*6] |-> ga == 4'h0 && gb == 4'h0)
		else $error("bridges driven while disabled");
	chk_sleep_gates: assert property (!low_power_n [*6] |-> ga == 4'h0 && gb == 4'h0)
		else $error("bridges driven in sleep");
	chk_ocp_home: assert property (overcurrent [*5] |-> !at_origin_n && ga == 4'h0 && gb == 4'h0)
		else $error("overcurrent did not stop and home");
	chk_home_flag: assert property (!at_origin_n |-> ref_scale_a == 7'h47 && ref_scale_b == 7'h47)
		else $error("home flag low away from home");
	// Sine and cosine pairs keep the sum of squares near full scale squared.
	chk_table_pair: assert property (int'(ref_scale_a) * int'(ref_scale_a) + int'(ref_scale_b) * int'(ref_scale_b)
		inside {[32'h0000_26AC:32'h0000_2774]})
		else $error("winding targets not a table pair");
	chk_no_short: assert property (!(ga[3] && ga[2]) && !(ga[1] && ga[0]) && !(gb[3] && gb[2]) && !(gb[1] && gb[0]))
		else $error("both FETs of one leg on");
	chk_hold_still: assert property ((!step && !overcurrent && indexer_clear_n) [*8] |->
		$stable(ref_scale_a) && $stable(ref_scale_b) && $stable(at_origin_n))
		else $error("indexer moved without a step");
endmodule
bind sic_top sic_top_chk chk_i (.clk, .rst_n, .step, .indexer_clear_n, .bridge_drive_on_n, .low_power_n,
	.overcurrent, .ref_scale_a, .ref_scale_b, .at_origin_n, .winding_term_pos_hs_a, .winding_term_pos_ls_a,
	.winding_term_neg_hs_a, .winding_term_neg_ls_a, .winding_term_pos_hs_b, .winding_term_pos_ls_b,
	.winding_term_neg_hs_b, .winding_term_neg_ls_b);
`default_nettype wire

// [tb_top.sv]
// Self-checking testbench for the stepper indexer and chopper.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [2:0] hsize = 3'h0;
	logic ms_hi = 1'b1;
	logic ms_lo = 1'b1;
	logic clr_n = 1'b1;
	logic en_n = 1'b0;
	logic lp_n = 1'b1;
	logic sr_n = 1'b1;
	logic ocp = 1'b0;
	logic cmp_a = 1'b0;
	logic zero_a = 1'b0;
	wire logic step;
	wire logic dir;
	wire logic hready;
	wire logic hresp;
	wire logic home_n;
	wire logic [31:0] hrdata;
	wire logic [6:0] ra;
	wire logic [6:0] rb;
	wire logic [3:0] ga;
	wire logic [3:0] gb;
	int err_count = 0;
	int total_checks = 0;
	logic [4:0] pos = 5'h04;
	logic [31:0] rd;
	logic [6:0] tab [9] = '{7'h64, 7'h62, 7'h5C, 7'h53, 7'h47, 7'h38, 7'h26, 7'h14, 7'h00};

	always #5 clk = ~clk;

	sic_motion_ctl mc (.clk(clk), .step(step), .dir(dir));
	// Bridge B shares bridge A's sense signals but keeps its default timing, so its phases differ.
	sic_top uut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.step(step), .dir(dir), .microstep_sel_hi(ms_hi), .microstep_sel_lo(ms_lo), .indexer_clear_n(clr_n),
		.bridge_drive_on_n(en_n), .low_power_n(lp_n), .sync_rectify_n(sr_n), .overcurrent(ocp),
		.cmp_a(cmp_a), .cmp_b(cmp_a), .zero_a(zero_a), .zero_b(zero_a), .ref_scale_a(ra), .ref_scale_b(rb),
		.winding_term_pos_hs_a(ga[3]), .winding_term_pos_ls_a(ga[2]), .winding_term_neg_hs_a(ga[1]),
		.winding_term_neg_ls_a(ga[0]), .winding_term_pos_hs_b(gb[3]), .winding_term_pos_ls_b(gb[2]),
		.winding_term_neg_hs_b(gb[1]), .winding_term_neg_ls_b(gb[0]), .at_origin_n(home_n));

	task automatic final_report;
		if (err_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		haddr <= {24'h00_0000, a};
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
		chk("hresp", 32'h0000_0000, {31'h0, hresp});
	endtask

	function automatic logic [6:0] mag(input logic [4:0] p);
		return (p[3:0] <= 4'h8) ? tab[p[3:0]] : tab[5'h10 - {1'b0, p[3:0]}];
	endfunction

	task automatic chk_pos;
		bus(1'b0, 8'h1C, 32'h0000_0000, rd);
		chk("position", {27'h0, pos}, {27'h0, rd[4:0]});
		chk("scale_a", {25'h0, mag(pos)}, {25'h0, ra});
		chk("scale_b", {25'h0, mag(pos - 5'h08)}, {25'h0, rb});
		chk("home_n", {31'h0, pos != 5'h04}, {31'h0, home_n});
		chk("pol_a", {31'h0, !(pos >= 5'h09 && pos <= 5'h17)}, {31'h0, rd[15]});
	endtask

	// Measures the current or next stretch of one gate pattern on bridge A, from now or its start to its end.
	task automatic meas(input logic [3:0] g, input int lo, input int hi);
		int i;
		int c;
		i = 0;
		c = 0;
		while (ga !== g && i < 500) begin
			@(posedge clk);
			i++;
		end
		while (ga === g && c < 500) begin
			@(posedge clk);
			c++;
		end
		chk("phase_length_ok", 32'h0000_0001, {31'h0, c >= lo && c <= hi});
	endtask

	// A new setting applies from the next off phase, so skip to the end of a drive phase first.
	task automatic settle;
		repeat (4) @(posedge clk);
		meas(4'b1001, 0, 12);
	endtask

	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		bus(1'b0, 8'h04, 32'h0000_0000, rd);
		chk("toff_a_reset", 32'h0000_0ED8, rd);
		bus(1'b0, 8'h0C, 32'h0000_0000, rd);
		chk("blank_a_reset", 32'h0000_005F, rd);
		bus(1'b0, 8'h14, 32'h0000_0000, rd);
		chk("fd_a_reset", 32'h0000_03E8, rd);
		bus(1'b1, 8'h04, 32'h0000_001E, rd);
		bus(1'b1, 8'h0C, 32'h0000_000A, rd);
		bus(1'b1, 8'h14, 32'h0000_000A, rd);
		bus(1'b0, 8'h08, 32'h0000_0000, rd);
		chk("toff_b_apart", 32'h0000_0ED8, rd);
		bus(1'b0, 8'h40, 32'h0000_0000, rd);
		chk("unmapped", 32'h0000_0000, rd);
		chk_pos;
		cmp_a <= 1'b1;
		meas(4'b0101, 28, 32);
		meas(4'b1001, 8, 12);
		bus(1'b1, 8'h00, 32'h0000_0001, rd);
		mc.pulse(1'b1);
		pos = pos + 5'h01;
		settle;
		meas(4'b0000, 28, 32);
		chk("gates_b_off", 32'h0000_0005, {28'h0, gb});
		sr_n <= 1'b0;
		settle;
		meas(4'b0110, 28, 32);
		zero_a <= 1'b1;
		settle;
		meas(4'b0000, 20, 32);
		zero_a <= 1'b0;
		bus(1'b1, 8'h00, 32'h0000_0002, rd);
		settle;
		meas(4'b0110, 8, 12);
		meas(4'b0101, 18, 22);
		mc.pulse(1'b0);
		pos = pos - 5'h01;
		settle;
		meas(4'b0101, 28, 32);
		cmp_a <= 1'b0;
		en_n <= 1'b1;
		mc.pulse(1'b1);
		pos = pos + 5'h01;
		chk_pos;
		en_n <= 1'b0;
		lp_n <= 1'b0;
		mc.pulse(1'b1);
		chk_pos;
		lp_n <= 1'b1;
		clr_n <= 1'b0;
		mc.pulse(1'b1);
		pos = 5'h04;
		chk_pos;
		clr_n <= 1'b1;
		mc.pulse(1'b1);
		pos = pos + 5'h01;
		ocp <= 1'b1;
		repeat (8) @(posedge clk);
		ocp <= 1'b0;
		pos = 5'h04;
		chk_pos;
		chk("fault_set", 32'h0000_0001, {31'h0, rd[6]});
		en_n <= 1'b1;
		repeat (6) @(posedge clk);
		en_n <= 1'b0;
		repeat (6) @(posedge clk);
		bus(1'b0, 8'h1C, 32'h0000_0000, rd);
		chk("fault_clear", 32'h0000_0000, {31'h0, rd[6]});
		for (int s = 0; s < 4; s++) begin
			ms_hi <= s[1];
			ms_lo <= s[0];
			for (int k = 0; k < 5; k++) begin
				mc.pulse(s[0]);
				pos = s[0] ? pos + (5'h08 >> s) : pos - (5'h08 >> s);
				chk_pos;
			end
		end
		final_report;
	end

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		final_report;
	end
endmodule
`default_nettype wire
